// File: cpu_ops_pkg.sv
// Constants shared by the subtract/shift/bank execution block.
// Assumes a single 25 MHz clock and AXI4-Lite register access.
package cpu_ops_pkg;
    // Flag register bit positions
    localparam int FLAG_C    = 7;
    localparam int FLAG_Z    = 6;
    localparam int FLAG_S    = 5;
    localparam int FLAG_V    = 4;
    localparam int FLAG_D    = 3;
    localparam int FLAG_H    = 2;
    localparam int FLAG_BANK = 0;
    // Register byte offsets
    localparam logic [3:0] OFS_CMD     = 4'h0;
    localparam logic [3:0] OFS_FLAGS   = 4'h4;
    localparam logic [3:0] OFS_POINTER = 4'h8;
    localparam logic [3:0] OFS_STATUS  = 4'hC;
    // Command word fields
    localparam int CMD_OP_LSB  = 16;
    localparam int CMD_SRC_LSB = 8;
    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] PTR0_RESET  = 8'hC0;
    localparam logic [7:0] PTR1_RESET  = 8'hC8;
    // Operation codes, same byte as the instruction opcodes
    localparam logic [7:0] OPC_SEL_BANK0 = 8'h4F;
    localparam logic [7:0] OPC_SEL_BANK1 = 8'h5F;
    localparam logic [7:0] OPC_SUB_BORROW = 8'h32;
    localparam logic [7:0] OPC_SUB        = 8'h22;
    localparam logic [7:0] OPC_SET_CARRY  = 8'hDF;
    localparam logic [7:0] OPC_SHIFT_RA   = 8'hD0;
    localparam logic [7:0] OPC_SET_PTR    = 8'h31;
    localparam logic [7:0] OPC_STOP       = 8'h7F;
    localparam logic [7:0] OPC_SWAP       = 8'hF0;
    localparam logic [7:0] OPC_TEST_CMASK = 8'h62;
    // Instruction length in clock cycles
    localparam logic [2:0] OP_CYCLES = 3'h4;
    // Oscillator stabilisation time in ns and derived cycles
    localparam int CLK_NS      = 40;
    localparam int STAB_NS     = 4000;
    localparam int STAB_CYCLES = (STAB_NS + CLK_NS - 1) / CLK_NS;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cpu_ops_pkg

// File: cpu_ops_alu.sv
// Combinational 8-bit datapath for the subtract, shift, swap and mask ops.
// Assumes operands and flags are stable during the executing instruction.
`timescale 1ns/10ps
module cpu_ops_alu (
    input  wire logic [7:0] op,
    input  wire logic [7:0] dst,
    input  wire logic [7:0] src,
    input  wire logic [7:0] flags_in,
    output logic      [7:0] result,
    output logic      [7:0] flags_out,
    output logic            write_dst
);
    logic [8:0] sum;   // Two's-complement add with carry out
    logic [4:0] low;   // Low nibble add for half-carry
    logic       cin;   // Add carry in (inverse of borrow)

    // Result and flag evaluation
    always_comb begin
        sum       = 9'h000;
        low       = 5'h00;
        cin       = 1'b1;
        result    = dst;
        flags_out = flags_in;
        write_dst = 1'b0;
        unique case (op)
            cpu_ops_pkg::OPC_SUB_BORROW,
            cpu_ops_pkg::OPC_SUB: begin
                // Borrow-in only for the with-borrow form
                cin = (op == cpu_ops_pkg::OPC_SUB_BORROW) ?
                      ~flags_in[cpu_ops_pkg::FLAG_C] : 1'b1;
                sum = {1'b0, dst} + {1'b0, ~src} + {8'h00, cin};
                low = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + {4'h0, cin};
                result    = sum[7:0];
                write_dst = 1'b1;
                flags_out[cpu_ops_pkg::FLAG_C] = ~sum[8];
                flags_out[cpu_ops_pkg::FLAG_Z] = (sum[7:0] == 8'h00);
                flags_out[cpu_ops_pkg::FLAG_S] = sum[7];
                flags_out[cpu_ops_pkg::FLAG_V] = (dst[7] != src[7]) &&
                                                 (sum[7] == src[7]);
                flags_out[cpu_ops_pkg::FLAG_D] = 1'b1;
                flags_out[cpu_ops_pkg::FLAG_H] = ~low[4];
            end
            cpu_ops_pkg::OPC_SHIFT_RA: begin
                result    = {dst[7], dst[7:1]};
                write_dst = 1'b1;
                flags_out[cpu_ops_pkg::FLAG_C] = dst[0];
                flags_out[cpu_ops_pkg::FLAG_Z] = (dst[7:1] == 7'h00) && !dst[7];
                flags_out[cpu_ops_pkg::FLAG_S] = dst[7];
                flags_out[cpu_ops_pkg::FLAG_V] = 1'b0;
            end
            cpu_ops_pkg::OPC_SWAP: begin
                result    = {dst[3:0], dst[7:4]};
                write_dst = 1'b1;
                // Carry and overflow undefined: left as they were
                flags_out[cpu_ops_pkg::FLAG_Z] = (dst == 8'h00);
                flags_out[cpu_ops_pkg::FLAG_S] = dst[3];
            end
            cpu_ops_pkg::OPC_TEST_CMASK: begin
                // Neither operand written
                flags_out[cpu_ops_pkg::FLAG_Z] = ((~dst & src) == 8'h00);
                flags_out[cpu_ops_pkg::FLAG_S] = ~dst[7] & src[7];
                flags_out[cpu_ops_pkg::FLAG_V] = 1'b0;
            end
            cpu_ops_pkg::OPC_SET_CARRY: begin
                flags_out[cpu_ops_pkg::FLAG_C] = 1'b1;
            end
            cpu_ops_pkg::OPC_SEL_BANK0: begin
                flags_out[cpu_ops_pkg::FLAG_BANK] = 1'b0;
            end
            cpu_ops_pkg::OPC_SEL_BANK1: begin
                flags_out[cpu_ops_pkg::FLAG_BANK] = 1'b1;
            end
            default: begin
                // Other ops leave flags alone
                write_dst = 1'b0;
            end
        endcase
    end
endmodule : cpu_ops_alu

// File: cpu_ops_core.sv
// Execution unit for bank select, subtracts, carry set, shift, pointer
// load, stop, swap and complement-mask test, with an AXI4-Lite slave.
// Assumes one 25 MHz clock; reset and external interrupt are synchronous.
//
// Overview of operation
// - Bank-zero op clears flag bit 0
// - Bank-one op sets flag bit 0
// - Subtract-borrow: dst minus src minus carry
// - Borrow sets carry; zero, sign from result
// - Overflow: opposite signs, result sign equals source
// - Subtracts force D; H set on nibble borrow
// - Plain subtract, same flags, no carry in
// - Set-carry forces carry, others unchanged, 4 cycles
// - Arithmetic right shift keeps bit 7
// - Shift flags: carry out, Z, S, V cleared
// - Pointer op decodes low two immediate bits
// - Both pointers: bit 3 forced zero/one
// - Stop halts clocks, keeps all register state
// - Stop ends on reset, or on interrupt then stabilise
// - Swap exchanges nibbles, sets Z and S
// - Complement-mask test sets Z, S, clears V
`timescale 1ns/10ps
module cpu_ops_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ext_interrupt,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             cpu_clk_run,
    output logic             busy
);
    // Execution states
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STOP, ST_STAB} exec_e;

    exec_e       state;          // Execution state
    exec_e       next_state;
    logic [7:0]  flags;          // Flag register
    logic [7:0]  next_flags;
    logic [7:0]  pointer_zero;   // Register pointer 0
    logic [7:0]  next_pointer_zero;
    logic [7:0]  pointer_one;    // Register pointer 1
    logic [7:0]  next_pointer_one;
    logic [7:0]  dst_reg;        // Destination operand / result
    logic [7:0]  next_dst_reg;
    logic [7:0]  src_reg;        // Source operand or immediate
    logic [7:0]  next_src_reg;
    logic [7:0]  op_reg;         // Operation in execution
    logic [7:0]  next_op_reg;
    logic [7:0]  cyc;            // Cycle counter in op or stabilisation
    logic [7:0]  next_cyc;
    logic        aw_held;        // Write address taken
    logic        next_aw_held;
    logic        w_held;         // Write data taken
    logic        next_w_held;
    logic [3:0]  aw_addr;        // Latched write address
    logic [3:0]  next_aw_addr;
    logic [31:0] w_data;         // Latched write data
    logic [31:0] next_w_data;
    logic [3:0]  w_strb;         // Latched strobes
    logic [3:0]  next_w_strb;
    logic        next_awready;
    logic        next_wready;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        next_run;
    logic        next_busy;
    logic [7:0]  alu_result;     // Datapath result
    logic [7:0]  alu_flags;      // Datapath flags
    logic        alu_write;      // Datapath writes destination

    // Command word field tops, declared ahead of their first use
    localparam int CMD_OP_MSB  = cpu_ops_pkg::CMD_OP_LSB + 7;
    localparam int CMD_SRC_MSB = cpu_ops_pkg::CMD_SRC_LSB + 7;

    // Address decode used by both read and write paths
    function automatic logic addr_known(input logic [3:0] a);
        return (a == cpu_ops_pkg::OFS_CMD) || (a == cpu_ops_pkg::OFS_FLAGS) ||
               (a == cpu_ops_pkg::OFS_POINTER) || (a == cpu_ops_pkg::OFS_STATUS);
    endfunction : addr_known

    // Datapath for the result-producing operations
    cpu_ops_alu u_alu (
        .op        (op_reg),
        .dst       (dst_reg),
        .src       (src_reg),
        .flags_in  (flags),
        .result    (alu_result),
        .flags_out (alu_flags),
        .write_dst (alu_write)
    );

    // Next-state logic for bus slave and execution
    always_comb begin
        logic do_write;
        do_write          = 1'b0;
        next_state        = state;
        next_flags        = flags;
        next_pointer_zero = pointer_zero;
        next_pointer_one  = pointer_one;
        next_dst_reg      = dst_reg;
        next_src_reg      = src_reg;
        next_op_reg       = op_reg;
        next_cyc          = cyc;
        next_aw_held      = aw_held;
        next_w_held       = w_held;
        next_aw_addr      = aw_addr;
        next_w_data       = w_data;
        next_w_strb       = w_strb;
        next_awready      = s_axi_awready;
        next_wready       = s_axi_wready;
        next_bvalid       = s_axi_bvalid;
        next_bresp        = s_axi_bresp;
        next_arready      = s_axi_arready;
        next_rvalid       = s_axi_rvalid;
        next_rdata        = s_axi_rdata;
        next_rresp        = s_axi_rresp;
        // Write channels taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
            next_awready = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
            next_wready = 1'b0;
        end
        // Commit write once both halves held
        if (aw_held && w_held && !s_axi_bvalid) begin
            do_write     = 1'b1;
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = addr_known(aw_addr) ? cpu_ops_pkg::RESP_OKAY
                                               : cpu_ops_pkg::RESP_SLVERR;
        end
        // Response accepted: reopen write channels
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end
        // Read address and data
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = addr_known(s_axi_araddr) ? cpu_ops_pkg::RESP_OKAY
                                                    : cpu_ops_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                cpu_ops_pkg::OFS_CMD:     next_rdata = {8'h00, op_reg, src_reg, dst_reg};
                cpu_ops_pkg::OFS_FLAGS:   next_rdata = {24'h000000, flags};
                cpu_ops_pkg::OFS_POINTER: next_rdata = {16'h0000, pointer_one,
                                                        pointer_zero};
                cpu_ops_pkg::OFS_STATUS:  next_rdata = {28'h0000000, 2'(state),
                                                        cpu_clk_run, busy};
                default:                  next_rdata = 32'h00000000;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        // Execution sequencer
        unique case (state)
            ST_IDLE: begin
                if (do_write && aw_addr == cpu_ops_pkg::OFS_CMD && w_strb[2]) begin
                    next_op_reg  = w_data[CMD_OP_MSB:cpu_ops_pkg::CMD_OP_LSB];
                    next_src_reg = w_data[CMD_SRC_MSB:cpu_ops_pkg::CMD_SRC_LSB];
                    if (w_strb[0]) begin
                        next_dst_reg = w_data[7:0];
                    end
                    next_cyc   = 8'h01;
                    next_state = ST_EXEC;
                end else if (do_write && aw_addr == cpu_ops_pkg::OFS_FLAGS
                             && w_strb[0]) begin
                    // Software may preset flags, e.g. carry before a borrow op
                    next_flags = w_data[7:0];
                end
            end
            ST_EXEC: begin
                // Every op here lasts four cycles; effect on the last
                if (cyc == {5'h00, cpu_ops_pkg::OP_CYCLES}) begin
                    next_flags = alu_flags;
                    if (alu_write) begin
                        next_dst_reg = alu_result;
                    end
                    next_state = ST_IDLE;
                    if (op_reg == cpu_ops_pkg::OPC_SET_PTR) begin
                        unique case (src_reg[1:0])
                            2'b10: next_pointer_zero = {src_reg[7:3], 3'h0};
                            2'b01: next_pointer_one  = {src_reg[7:3], 3'h0};
                            2'b00: begin
                                next_pointer_zero = {src_reg[7:4], 4'h0};
                                next_pointer_one  = {src_reg[7:4], 4'h8};
                            end
                            default: next_pointer_zero = pointer_zero;
                        endcase
                    end else if (op_reg == cpu_ops_pkg::OPC_STOP) begin
                        next_state = ST_STOP;
                    end
                end else begin
                    next_cyc = cyc + 8'h01;
                end
            end
            ST_STOP: begin
                // Registers hold; only an interrupt wakes (reset is global)
                if (ext_interrupt) begin
                    next_cyc   = 8'h00;
                    next_state = ST_STAB;
                end
            end
            ST_STAB: begin
                // Wait oscillator stabilisation before resuming
                if (cyc == 8'(cpu_ops_pkg::STAB_CYCLES - 1)) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cyc = cyc + 8'h01;
                end
            end
        endcase
        next_run  = (next_state != ST_STOP) && (next_state != ST_STAB);
        next_busy = (next_state != ST_IDLE);
    end

    // Register all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state         <= ST_IDLE;
            flags         <= cpu_ops_pkg::FLAGS_RESET;
            pointer_zero  <= cpu_ops_pkg::PTR0_RESET;
            pointer_one   <= cpu_ops_pkg::PTR1_RESET;
            dst_reg       <= 8'h00;
            src_reg       <= 8'h00;
            op_reg        <= 8'h00;
            cyc           <= 8'h00;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cpu_ops_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= cpu_ops_pkg::RESP_OKAY;
            cpu_clk_run   <= 1'b1;
            busy          <= 1'b0;
        end else begin
            state         <= next_state;
            flags         <= next_flags;
            pointer_zero  <= next_pointer_zero;
            pointer_one   <= next_pointer_one;
            dst_reg       <= next_dst_reg;
            src_reg       <= next_src_reg;
            op_reg        <= next_op_reg;
            cyc           <= next_cyc;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            cpu_clk_run   <= next_run;
            busy          <= next_busy;
        end
    end

    // Checks next to the logic they guard
    AST_BANK0: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_EXEC && cyc == 8'h04 && op_reg == cpu_ops_pkg::OPC_SEL_BANK0)
        |=> (flags[cpu_ops_pkg::FLAG_BANK] == 1'b0) && (flags[7:1] == $past(flags[7:1])))
        else $error("bank zero select wrong");
    AST_BANK1: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_EXEC && cyc == 8'h04 && op_reg == cpu_ops_pkg::OPC_SEL_BANK1)
        |=> flags[cpu_ops_pkg::FLAG_BANK])
        else $error("bank one select wrong");
    AST_SUBD: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_EXEC && cyc == 8'h04 && op_reg == cpu_ops_pkg::OPC_SUB)
        |=> flags[cpu_ops_pkg::FLAG_D] && (dst_reg == $past(dst_reg) - $past(src_reg)))
        else $error("subtract result or D wrong");
    AST_SCF: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_IDLE && next_state == ST_EXEC && next_op_reg == cpu_ops_pkg::OPC_SET_CARRY)
        |=> ##3 (state == ST_EXEC) ##1 (flags[cpu_ops_pkg::FLAG_C] && state == ST_IDLE))
        else $error("set carry timing wrong");
    AST_SRA: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_EXEC && cyc == 8'h04 && op_reg == cpu_ops_pkg::OPC_SHIFT_RA)
        |=> dst_reg == {$past(dst_reg[7]), $past(dst_reg[7:1])}
            && !flags[cpu_ops_pkg::FLAG_V])
        else $error("arith shift wrong");
    AST_PTR: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_EXEC && cyc == 8'h04 && op_reg == cpu_ops_pkg::OPC_SET_PTR
         && src_reg[1:0] == 2'b00)
        |=> !pointer_zero[3] && pointer_one[3])
        else $error("pointer bit 3 wrong");
    AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_STOP) |-> !cpu_clk_run && $stable(flags) && $stable(pointer_zero))
        else $error("stop mode not holding");
    AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_STOP && !ext_interrupt) |=> state == ST_STOP)
        else $error("stop left without interrupt");
endmodule : cpu_ops_core

// File: tb.sv
// Self-checking bench: runs each op through the AXI4-Lite command port.
// Assumes cpu_ops_core with the register map and op codes of cpu_ops_pkg.
`timescale 1ns/10ps
module tb;
    logic        aclk = 1'b0;          // 25 MHz clock
    logic        aresetn = 1'b0;       // Sync reset, active low
    logic        ext_interrupt = 1'b0; // Stop-mode wake request
    logic [3:0]  awaddr = 4'h0;        // Write address
    logic [3:0]  araddr = 4'h0;        // Read address
    logic [31:0] wdata = 32'h0;        // Write data
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, clk_run, busy;
    logic [1:0]  bresp, rresp, rs;     // Responses; last one taken
    logic [31:0] rdata, rdv;           // Read data; last one taken
    int          failures = 0, tests_run = 0, cyc = 0, n;
    logic [7:0]  psrc [3] = '{8'h40, 8'h52, 8'h69};      // Pointer immediates
    logic [15:0] pexp [3] = '{16'h4840, 16'h4850, 16'h6850};

    // Clock
    always #20 aclk = ~aclk;

    cpu_ops_core DUT (.aclk(aclk), .aresetn(aresetn), .ext_interrupt(ext_interrupt),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_clk_run(clk_run), .busy(busy));

    // Verdict and end of run
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    // Compare seen against expected
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // AXI4-Lite write: address and data together, each released when taken
    task axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axw

    // AXI4-Lite read
    task axr(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rdv = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : axr

    // Preset flags, run one op, check its length, result and flags
    task op(input logic [7:0] fl, oc, s, d, er, ef);
        axw(cpu_ops_pkg::OFS_FLAGS, {24'h0, fl});
        axw(cpu_ops_pkg::OFS_CMD, {8'h00, oc, s, d});
        n = 0;
        while (busy === 1'b1 && n < 50) begin
            n++;
            @(posedge aclk);
        end
        check("op cycles", n, 4);
        axr(cpu_ops_pkg::OFS_CMD);
        check("result", {24'h0, rdv[7:0]}, {24'h0, er});
        axr(cpu_ops_pkg::OFS_FLAGS);
        check("flags", {24'h0, rdv[7:0]}, {24'h0, ef});
    endtask : op

    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axr(cpu_ops_pkg::OFS_POINTER);
        check("pointer reset", rdv, 32'h0000C8C0);
        axr(4'h2);
        check("unmapped resp", rs, cpu_ops_pkg::RESP_SLVERR);
        axw(4'h2, 32'h00000000);
        check("unmapped write", rs, cpu_ops_pkg::RESP_SLVERR);
        $display("test reset done");
        op(8'h00, 8'h5F, 8'h00, 8'h11, 8'h11, 8'h01);
        op(8'hFD, 8'h4F, 8'h00, 8'h11, 8'h11, 8'hFC);
        op(8'h81, 8'h32, 8'h03, 8'h10, 8'h0C, 8'h0D);
        op(8'h80, 8'h32, 8'h8A, 8'h20, 8'h95, 8'hBC);
        op(8'h80, 8'h22, 8'h03, 8'h12, 8'h0F, 8'h0C);
        op(8'h00, 8'h22, 8'h90, 8'h21, 8'h91, 8'hB8);
        op(8'h01, 8'h22, 8'h05, 8'h05, 8'h00, 8'h49);
        op(8'h7D, 8'hDF, 8'h00, 8'h22, 8'h22, 8'hFD);
        op(8'h9C, 8'hD0, 8'h00, 8'h9A, 8'hCD, 8'h2C);
        op(8'h00, 8'hD0, 8'h00, 8'h01, 8'h00, 8'hC0);
        op(8'h9C, 8'hF0, 8'h00, 8'h3E, 8'hE3, 8'hBC);
        op(8'h00, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h40);
        op(8'h9C, 8'h62, 8'h02, 8'hC7, 8'hC7, 8'hCC);
        op(8'h10, 8'h62, 8'h80, 8'h00, 8'h00, 8'h20);
        $display("test ops done");
        foreach (psrc[i]) begin
            op(8'h00, 8'h31, psrc[i], 8'h00, 8'h00, 8'h00);
            axr(cpu_ops_pkg::OFS_POINTER);
            check("pointers", rdv, {16'h0, pexp[i]});
        end
        // Second command while busy is ignored
        axw(cpu_ops_pkg::OFS_CMD, 32'h005F0000);
        axw(cpu_ops_pkg::OFS_CMD, 32'h00DF0000);
        check("refused resp", rs, cpu_ops_pkg::RESP_OKAY);
        repeat (8) @(posedge aclk);
        axr(cpu_ops_pkg::OFS_FLAGS);
        check("busy refuse", rdv[7:0], 8'h01);
        $display("test pointer done");
        // Stop, then wake by interrupt
        axw(cpu_ops_pkg::OFS_FLAGS, 32'h85);
        axw(cpu_ops_pkg::OFS_CMD, 32'h007F0000);
        for (n = 0; n < 20 && clk_run === 1'b1; n++) @(posedge aclk);
        check("clock halted", clk_run, 1'b0);
        axr(cpu_ops_pkg::OFS_STATUS);
        check("stop status", rdv, 32'h9);
        ext_interrupt <= 1'b1;
        for (n = 0; n < 500 && clk_run !== 1'b1; n++) @(posedge aclk);
        ext_interrupt <= 1'b0;
        check("stab time", n >= cpu_ops_pkg::STAB_CYCLES &&
              n <= cpu_ops_pkg::STAB_CYCLES + 4, 1'b1);
        // Three idle instruction slots after wake, as the program must leave
        repeat (3 * cpu_ops_pkg::OP_CYCLES) @(posedge aclk);
        axr(cpu_ops_pkg::OFS_FLAGS);
        check("flags kept", rdv[7:0], 8'h85);
        axr(cpu_ops_pkg::OFS_POINTER);
        check("pointers kept", rdv, 32'h6850);
        // Stop, then release by a long reset
        axw(cpu_ops_pkg::OFS_CMD, 32'h007F0000);
        for (n = 0; n < 20 && clk_run === 1'b1; n++) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (cpu_ops_pkg::STAB_CYCLES) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("reset wake", clk_run, 1'b1);
        axr(cpu_ops_pkg::OFS_STATUS);
        check("reset status", rdv, 32'h2);
        axr(cpu_ops_pkg::OFS_POINTER);
        check("reset pointers", rdv, 32'h0000C8C0);
        $display("test stop done");
        tally_and_finish();
    end
endmodule : tb
